// file: pch_pkg.sv
// Package with constants and types for the printer code handshake host
package pch_pkg;
  localparam int CodeWidth = 5;
  localparam int FifoDepth = 16;
  localparam int FifoAddrW = 4;
  // Code magnets settle before the solenoid is energized
  localparam int SetupTimeNs = 1000;
  localparam int ClockPeriodNs = 10;
  localparam int SetupCycles = (SetupTimeNs + ClockPeriodNs - 1) / ClockPeriodNs;
  localparam int SetupCntW = 8;
  localparam logic [CodeWidth-1:0] CodeReset = 5'h00;
  localparam logic [CodeWidth-1:0] CodeSeven = 5'h07;
  localparam logic [CodeWidth-1:0] CodeSpace = 5'h04;
  localparam logic [SetupCntW-1:0] SetupLast = SetupCntW'(SetupCycles - 1);

  typedef enum logic [4:0] {
    PCH_IDLE = 5'b0_0001,
    PCH_SETUP = 5'b0_0010,
    PCH_PRINT = 5'b0_0100,
    PCH_RELEASE = 5'b0_1000,
    PCH_VERIFY = 5'b1_0000
  } pch_state_t;
endpackage

// file: pch_stream_if.sv
// Interface carrying a valid and ready word stream between modules
`timescale 1ns/1ps
interface pch_stream_if;
  import pch_pkg::*;
  logic valid;
  logic ready;
  logic [CodeWidth-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// file: pch_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module pch_fifo #(
  parameter int Width = 5,
  parameter int Depth = 16,
  parameter int AddrW = 4
) (
  input wire logic clock,
  input wire logic resetn,
  pch_stream_if.sink inPort,
  pch_stream_if.source outPort
);
  logic [Width-1:0] mem_r [Depth];
  logic [AddrW-1:0] wrPtr_r;
  logic [AddrW-1:0] rdPtr_r;
  logic [AddrW:0] count_r;
  logic doWrite;
  logic doRead;

  assign inPort.ready = (count_r != (AddrW+1)'(Depth));
  assign outPort.valid = (count_r != '0);
  assign outPort.data = mem_r[rdPtr_r];
  assign doWrite = inPort.valid && inPort.ready;
  assign doRead = outPort.valid && outPort.ready;

  genvar gi;
  generate
    for (gi = 0; gi < Depth; gi++) begin : gEntry
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          mem_r[gi] <= '0;
        end else if (doWrite && wrPtr_r == AddrW'(gi)) begin
          mem_r[gi] <= inPort.data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRead) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_r <= count_r + 1'b1;
      end else if (doRead && !doWrite) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  a_fifo_count: assert property (@(posedge clock) disable iff (!resetn)
    count_r <= (AddrW+1)'(Depth)) else $error("FIFO count above depth");
endmodule

// file: pch_host.sv
// Computer-side controller that prints characters and checks the echo
`timescale 1ns/1ps
// Notes on behaviour
// - Host pulses activate; device performs one half-revolution cycle.
// - Code is settled on the magnets before the activate pulse rises.
// - On termination request the host drops the activate signal.
// - Only after the completion reset may the host send the next code.
module pch_host
  import pch_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic charValid,
  output logic charReady,
  input wire logic [CodeWidth-1:0] charCode,
  input wire logic powerOn,
  output logic [CodeWidth-1:0] codeMagnets,
  output logic activatePrintPulse,
  input wire logic terminationRequest,
  input wire logic completionReset,
  input wire logic [CodeWidth-1:0] oneBitLine,
  input wire logic [CodeWidth-1:0] zeroBitGate,
  output logic echoValid,
  output logic echoError,
  output logic [CodeWidth-1:0] echoCode,
  output logic keyedValid,
  output logic [CodeWidth-1:0] keyedCode,
  output logic busy
);
  pch_stream_if inStream ();
  pch_stream_if outStream ();
  pch_state_t state_r;
  pch_state_t state_nxt;
  logic [SetupCntW-1:0] setupCnt_r;
  logic [CodeWidth-1:0] echoSeen_r;
  logic [CodeWidth-1:0] zeroSeen_r;
  logic echoComplete;
  logic take;

  assign inStream.valid = charValid;
  assign inStream.data = charCode;
  // Take only in idle with power on, so a code never lands mid-print
  assign take = (state_r == PCH_IDLE) && outStream.valid && powerOn;
  assign outStream.ready = take;

  pch_fifo #(.Width(CodeWidth), .Depth(FifoDepth), .AddrW(FifoAddrW)) uFifo (
    .clock(clock),
    .resetn(resetn),
    .inPort(inStream),
    .outPort(outStream)
  );

  // Echo is complete when every channel has reported either a one or a zero
  assign echoComplete = &(echoSeen_r | zeroSeen_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PCH_IDLE: begin
        if (take) begin
          state_nxt = PCH_SETUP;
        end
      end
      PCH_SETUP: begin
        if (setupCnt_r == SetupLast) begin
          state_nxt = PCH_PRINT;
        end
      end
      PCH_PRINT: begin
        if (terminationRequest) begin
          state_nxt = PCH_RELEASE;
        end
      end
      PCH_RELEASE: begin
        if (completionReset) begin
          state_nxt = PCH_VERIFY;
        end
      end
      PCH_VERIFY: begin
        state_nxt = PCH_IDLE;
      end
      default: begin
        state_nxt = PCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= PCH_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      setupCnt_r <= '0;
    end else if (state_r == PCH_SETUP) begin
      setupCnt_r <= setupCnt_r + 1'b1;
    end else begin
      setupCnt_r <= '0;
    end
  end

  // Code stays on the magnets from setup through verify
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      codeMagnets <= CodeReset;
    end else if (take) begin
      codeMagnets <= outStream.data;
    end else if (state_r == PCH_VERIFY) begin
      codeMagnets <= CodeReset;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      activatePrintPulse <= 1'b0;
    end else begin
      activatePrintPulse <= (state_nxt == PCH_PRINT);
    end
  end

  // Echo pulses are gathered per channel while the print is in progress
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      echoSeen_r <= '0;
      zeroSeen_r <= '0;
    end else if (state_r == PCH_IDLE) begin
      echoSeen_r <= '0;
      zeroSeen_r <= '0;
    end else if (state_r == PCH_PRINT || state_r == PCH_RELEASE) begin
      echoSeen_r <= echoSeen_r | oneBitLine;
      zeroSeen_r <= zeroSeen_r | zeroBitGate;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      echoValid <= 1'b0;
      echoError <= 1'b0;
      echoCode <= CodeReset;
    end else begin
      echoValid <= (state_r == PCH_VERIFY);
      if (state_r == PCH_VERIFY) begin
        // Error covers missing channels, wrong ones and conflicting reports
        echoCode <= echoSeen_r;
        echoError <= !echoComplete || (echoSeen_r != codeMagnets) ||
          ((echoSeen_r & zeroSeen_r) != '0);
      end
    end
  end

  // Keyed characters arrive while the host is not printing
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      keyedValid <= 1'b0;
      keyedCode <= CodeReset;
    end else begin
      keyedValid <= (state_r == PCH_IDLE) && completionReset && (oneBitLine != '0);
      if ((state_r == PCH_IDLE) && (oneBitLine != '0)) begin
        keyedCode <= oneBitLine;
      end
    end
  end

  // Ready is a registered copy, so it lags the FIFO by one cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      charReady <= 1'b0;
      busy <= 1'b0;
    end else begin
      charReady <= inStream.ready;
      busy <= (state_nxt != PCH_IDLE);
    end
  end

  // Checks on the handshake toward the printer
  a_setup_count: assert property (@(posedge clock) disable iff (!resetn)
    $rose(activatePrintPulse) |-> $past(setupCnt_r) == SetupLast)
    else $error("Activate rose before the full setup time");
  a_act_after_setup: assert property (@(posedge clock) disable iff (!resetn)
    $rose(activatePrintPulse) |-> $past(state_r) == PCH_SETUP)
    else $error("Activate rose without code setup");
  a_code_held: assert property (@(posedge clock) disable iff (!resetn)
    (activatePrintPulse && $past(activatePrintPulse)) |-> $stable(codeMagnets))
    else $error("Code changed during activate");
  a_drop_on_term: assert property (@(posedge clock) disable iff (!resetn)
    (state_r == PCH_PRINT && terminationRequest) |=> !activatePrintPulse)
    else $error("Activate not removed after termination");
  a_wait_complete: assert property (@(posedge clock) disable iff (!resetn)
    (state_r == PCH_RELEASE && !completionReset) |=> state_r == PCH_RELEASE)
    else $error("Left release before completion reset");
  a_power_gate: assert property (@(posedge clock) disable iff (!resetn)
    $rose(busy) |-> $past(powerOn))
    else $error("Print started with power off");
  a_one_code: assert property (@(posedge clock) disable iff (!resetn)
    take |=> codeMagnets == $past(outStream.data))
    else $error("Magnets not loaded with taken code");
  a_act_state: assert property (@(posedge clock) disable iff (!resetn)
    $fell(activatePrintPulse) |-> $past(terminationRequest))
    else $error("Activate dropped without termination request");
  a_verify_pulse: assert property (@(posedge clock) disable iff (!resetn)
    echoValid |=> !echoValid)
    else $error("Echo valid longer than one cycle");
endmodule

// file: pch_typer_model.sv
// Behavioural model of the printing and keying unit on the far side of the host
`timescale 1ns/1ps
module pch_typer_model
  import pch_pkg::*;
(
  input wire logic clock,
  input wire logic powerOn,
  input wire logic [CodeWidth-1:0] codeMagnets,
  input wire logic activatePrintPulse,
  input wire logic slow,
  input wire logic flip,
  input wire logic [CodeWidth-1:0] keyCode,
  output logic terminationRequest,
  output logic completionReset,
  output logic [CodeWidth-1:0] oneBitLine,
  output logic [CodeWidth-1:0] zeroBitGate
);
  logic [CodeWidth-1:0] code;
  initial begin
    terminationRequest = 1'b0;
    completionReset = 1'b1;
    oneBitLine = 5'h00;
    zeroBitGate = 5'h00;
    forever begin
      @(posedge clock);
      if (activatePrintPulse === 1'b1 && powerOn === 1'b1) begin
        code = codeMagnets;
        repeat (slow ? 20 : 2) @(posedge clock);
        // Flip only when a scenario asks for a bad echo
        // Echo is the received code, and the zero gates carry its inverse
        oneBitLine <= code ^ {4'h0, flip};
        zeroBitGate <= ~code;
        terminationRequest <= 1'b1;
        completionReset <= 1'b0;
        // One stroke per energized period
        while (activatePrintPulse === 1'b1) @(posedge clock);
        repeat (slow ? 20 : 2) @(posedge clock);
        terminationRequest <= 1'b0;
        completionReset <= 1'b1;
        // Code contacts fall back together with the shared contact
        oneBitLine <= 5'h00;
        zeroBitGate <= 5'h00;
        repeat (3) @(posedge clock);
      end else begin
        oneBitLine <= keyCode;
        zeroBitGate <= (keyCode == 5'h00) ? 5'h00 : ~keyCode;
      end
    end
  end
endmodule

// file: tb_pch_host.sv
// Self-checking testbench for the printer code handshake host
`timescale 1ns/1ps
module tb_pch_host;
  import pch_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic charValid = 1'b0;
  logic powerOn = 1'b1;
  logic slow = 1'b0;
  logic flip = 1'b0;
  logic [CodeWidth-1:0] charCode = 5'h00;
  logic [CodeWidth-1:0] keyCode = 5'h00;
  logic charReady, activatePrintPulse, terminationRequest, completionReset;
  logic echoValid, echoError, keyedValid, busy;
  logic [CodeWidth-1:0] codeMagnets, oneBitLine, zeroBitGate, echoCode, keyedCode;
  int badCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  pch_host DUT (.clock(clock), .resetn(resetn), .charValid(charValid), .charReady(charReady),
    .charCode(charCode), .powerOn(powerOn), .codeMagnets(codeMagnets),
    .activatePrintPulse(activatePrintPulse), .terminationRequest(terminationRequest),
    .completionReset(completionReset), .oneBitLine(oneBitLine), .zeroBitGate(zeroBitGate),
    .echoValid(echoValid), .echoError(echoError), .echoCode(echoCode),
    .keyedValid(keyedValid), .keyedCode(keyedCode), .busy(busy));
  pch_typer_model partner (.clock(clock), .powerOn(powerOn), .codeMagnets(codeMagnets),
    .activatePrintPulse(activatePrintPulse), .slow(slow), .flip(flip), .keyCode(keyCode),
    .terminationRequest(terminationRequest), .completionReset(completionReset),
    .oneBitLine(oneBitLine), .zeroBitGate(zeroBitGate));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic endSim();
    $display("checks=%0d mismatches=%0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      badCount++;
      endSim();
    end
  end
  task automatic push(input logic [4:0] c);
    @(negedge clock);
    charValid = 1'b1;
    charCode = c;
    @(negedge clock);
    charValid = 1'b0;
  endtask
  task automatic waitEcho();
    int n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (echoValid !== 1'b1 && n < 3000);
    check(echoValid, 1);
  endtask
  task automatic testSetup();
    int n = 0;
    push(CodeSeven);
    while (codeMagnets !== CodeSeven && n < 50) begin
      @(posedge clock);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (activatePrintPulse !== 1'b1 && n < 300);
    check(n, SetupCycles);
    check(busy, 1);
    check(codeMagnets, CodeSeven);
    n = 0;
    while (terminationRequest !== 1'b1) @(posedge clock);
    while (activatePrintPulse !== 1'b0 && n < 10) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n <= 3, 1);
    check(codeMagnets, CodeSeven);
    waitEcho();
    check({echoCode, echoError}, {CodeSeven, 1'b0});
    $display("setup test done");
  endtask
  task automatic testCodes();
    logic [4:0] codes [3] = '{CodeSpace, 5'h1F, 5'h00};
    slow = 1'b1;
    foreach (codes[i]) push(codes[i]);
    foreach (codes[i]) begin
      waitEcho();
      check({echoCode, echoError}, {codes[i], 1'b0});
    end
    slow = 1'b0;
    $display("codes test done");
  endtask
  task automatic testFault();
    flip = 1'b1;
    push(CodeSeven);
    waitEcho();
    check(echoError, 1);
    flip = 1'b0;
    $display("fault test done");
  endtask
  task automatic testFill();
    @(negedge clock);
    powerOn = 1'b0;
    for (int i = 0; i < 20; i++) begin
      charValid = 1'b1;
      charCode = 5'(i);
      @(negedge clock);
    end
    charValid = 1'b0;
    repeat (3) @(negedge clock);
    check(charReady, 0);
    check({activatePrintPulse, busy}, 0);
    powerOn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      waitEcho();
      check(echoCode, 5'(i));
    end
    check(charReady, 1);
    $display("fill test done");
  endtask
  task automatic testKeyed();
    int n = 0;
    repeat (4) @(negedge clock);
    check(keyedValid, 0);
    keyCode = 5'h0B;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (keyedValid !== 1'b1 && n < 10);
    check({keyedValid, keyedCode}, {1'b1, 5'h0B});
    @(negedge clock);
    keyCode = 5'h00;
    $display("keyed test done");
  endtask
  initial begin
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    testSetup();
    testCodes();
    testFault();
    testFill();
    testKeyed();
    endSim();
  end
endmodule
